// File: logic/arr_irq.sv
// Sticky interrupt status, mask and level interrupt output
`timescale 1ns/1ps
`default_nettype none
`include "arr_map.svh"
module arr_irq (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [`ARR_IRQ_WIDTH-1:0] event_in,
    input wire logic [`ARR_IRQ_WIDTH-1:0] clear_in,
    input wire logic mask_we_in,
    input wire logic [`ARR_IRQ_WIDTH-1:0] mask_wdata_in,
    output logic [`ARR_IRQ_WIDTH-1:0] status_out,
    output logic [`ARR_IRQ_WIDTH-1:0] mask_out,
    output logic irq_out
);
    logic [`ARR_IRQ_WIDTH-1:0] status_d;
    logic irq_d;

    // Set beats clear so an event in the clearing cycle survives
    assign status_d = (status_out & ~clear_in) | event_in;
    assign irq_d = |(status_d & mask_out);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            status_out <= '0;
            mask_out <= `ARR_MASK_RESET;
            irq_out <= 1'b0;
        end else begin
            status_out <= status_d;
            if (mask_we_in) begin
                mask_out <= mask_wdata_in;
            end
            irq_out <= mask_we_in ? |(status_d & mask_wdata_in) : irq_d;
        end
    end
endmodule
`default_nettype wire

// File: logic/arr_map.svh
// Register offsets, field positions and reset values for the ADC result readout
`ifndef ARR_MAP_SVH
`define ARR_MAP_SVH
`define ARR_IDX_RESULT_HIGH 12'hf72
`define ARR_IDX_RESULT_LOW 12'hf73
`define ARR_ADDR_RESULT_HIGH 14'h3dc8
`define ARR_ADDR_RESULT_LOW 14'h3dcc
`define ARR_ADDR_IRQ_STATUS 14'h3dd0
`define ARR_ADDR_IRQ_MASK 14'h3dd4
`define ARR_ADDR_RAW_RESULT 14'h3dd8
`define ARR_ADDR_WIDTH 14
`define ARR_LOW_FIELD_LSB 3
`define ARR_OVF_BIT 0
`define ARR_IRQ_DONE_BIT 0
`define ARR_IRQ_OVF_BIT 1
`define ARR_IRQ_WIDTH 2
`define ARR_MASK_RESET 2'h0
`define ARR_HTRANS_NONSEQ 2'h2
`endif

// File: logic/arr_pkg.sv
// Types shared by the ADC result readout files
package arr_pkg;
    typedef struct packed {
        logic [12:0] value;
        logic overflow;
    } arr_result_type;

    typedef struct packed {
        logic sel;
        logic write;
        logic [1:0] trans;
        logic [31:0] addr;
        logic ready;
    } arr_ahb_req_type;
endpackage

// File: logic/arr_top.sv
// ADC conversion result readout with AHB-Lite register slave
// How it works
// - High-byte register shows result bits of highest eight significance.
// - Result is a 13-bit two's complement value split over two bytes.
// - Five lowest result bits sit in the upper part of the low byte.
// - Low byte also carries the overflow status flag.
// - Reading high byte snapshots low bits and overflow for coherent reads.
// - Low-byte register is read-only; writes change nothing.
// - Continuous mode keeps the latest completed conversion in the registers.
// - Result bits are undefined after reset; no initial value promised.
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "arr_map.svh"
module arr_top
    import arr_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic conv_done_in,
    input wire logic [12:0] conv_value_in,
    input wire logic conv_overflow_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic irq_out
);
    arr_result_type result_q;
    arr_result_type result_d;
    logic [4:0] low_bits_q;
    logic low_ovf_q;
    logic [2:0] done_sync_q;
    logic [12:0] value_s1_q;
    logic [12:0] value_s2_q;
    logic ovf_s1_q;
    logic ovf_s2_q;
    logic dphase_q;
    logic dwrite_q;
    logic [`ARR_ADDR_WIDTH-1:0] daddr_q;
    logic [31:0] hrdata_d;
    logic addr_phase;
    logic rd_take;
    logic rd_high;
    logic wr_active;
    logic conv_event;
    logic [`ARR_IRQ_WIDTH-1:0] irq_events;
    logic [`ARR_IRQ_WIDTH-1:0] irq_clear;
    logic [`ARR_IRQ_WIDTH-1:0] irq_status;
    logic [`ARR_IRQ_WIDTH-1:0] irq_mask;
    logic mask_we;
    logic [7:0] high_byte;
    logic [7:0] low_byte;
    logic [`ARR_ADDR_WIDTH-1:0] req_addr;

    // Converter signals come from another timing domain; done is edge-detected
    // on the second stage only, data is stable by then
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            done_sync_q <= 3'h0;
        end else begin
            done_sync_q <= {done_sync_q[1:0], conv_done_in};
        end
    end

    always_ff @(posedge clk_in) begin
        value_s1_q <= conv_value_in;
        value_s2_q <= value_s1_q;
        ovf_s1_q <= conv_overflow_in;
        ovf_s2_q <= ovf_s1_q;
    end

    assign conv_event = done_sync_q[1] & ~done_sync_q[2];

    // Result storage carries no reset: its content after reset is undefined
    assign result_d.value = conv_event ? value_s2_q : result_q.value;
    assign result_d.overflow = conv_event ? ovf_s2_q : result_q.overflow;

    always_ff @(posedge clk_in) begin
        result_q <= result_d;
    end

    // AHB-Lite address phase decode
    assign addr_phase = hsel_in & hready_in & htrans_in[1];
    assign req_addr = haddr_in[`ARR_ADDR_WIDTH-1:0];
    assign rd_take = addr_phase & ~hwrite_in;
    assign rd_high = rd_take & (req_addr == `ARR_ADDR_RESULT_HIGH);

    // Snapshot happens at the address phase of the high read, so the low
    // byte read that follows sees the partner of this high byte
    always_ff @(posedge clk_in) begin
        if (rd_high) begin
            low_bits_q <= result_q.value[4:0];
            low_ovf_q <= result_q.overflow;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            dphase_q <= 1'b0;
            dwrite_q <= 1'b0;
            daddr_q <= '0;
        end else begin
            dphase_q <= addr_phase;
            dwrite_q <= addr_phase & hwrite_in;
            daddr_q <= req_addr;
        end
    end

    assign high_byte = result_q.value[12:5];
    // Reserved bits 2..1 read zero
    assign low_byte = {low_bits_q, 2'h0, low_ovf_q};

    // Read data is registered and presented in the data phase, zero wait
    always_comb begin
        hrdata_d = 32'h0;
        if (rd_take) begin
            case (req_addr)
                `ARR_ADDR_RESULT_HIGH: hrdata_d = {24'h0, high_byte};
                `ARR_ADDR_RESULT_LOW: hrdata_d = {24'h0, low_byte};
                `ARR_ADDR_IRQ_STATUS: hrdata_d = {30'h0, irq_status};
                `ARR_ADDR_IRQ_MASK: hrdata_d = {30'h0, irq_mask};
                `ARR_ADDR_RAW_RESULT: hrdata_d = {18'h0, result_q.value, result_q.overflow};
                default: hrdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            hrdata_out <= 32'h0;
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
        end else begin
            hrdata_out <= hrdata_d;
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
        end
    end

    // Writes land in the data phase; result registers ignore them
    assign wr_active = dphase_q & dwrite_q;
    assign mask_we = wr_active & (daddr_q == `ARR_ADDR_IRQ_MASK);
    assign irq_clear = (wr_active & (daddr_q == `ARR_ADDR_IRQ_STATUS)) ?
        hwdata_in[`ARR_IRQ_WIDTH-1:0] : '0;
    assign irq_events[`ARR_IRQ_DONE_BIT] = conv_event;
    assign irq_events[`ARR_IRQ_OVF_BIT] = conv_event & ovf_s2_q;

    arr_irq u_irq (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .event_in(irq_events),
        .clear_in(irq_clear),
        .mask_we_in(mask_we),
        .mask_wdata_in(hwdata_in[`ARR_IRQ_WIDTH-1:0]),
        .status_out(irq_status),
        .mask_out(irq_mask),
        .irq_out(irq_out)
    );

    // hsize is accepted but only whole-word accesses are supported
    logic unused_ok;
    assign unused_ok = &{1'b0, hsize_in, hwdata_in[31:`ARR_IRQ_WIDTH], haddr_in[31:`ARR_ADDR_WIDTH]};
endmodule
`default_nettype wire

// File: sim/arr_top_asserts.sv
// Port-level checker for the result readout
`timescale 1ns/1ps
`default_nettype none
`include "arr_map.svh"
module arr_top_asserts (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic conv_done_in,
    input wire logic [12:0] conv_value_in,
    input wire logic conv_overflow_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic hreadyout_out,
    input wire logic hresp_out
);
    logic done_q, rd_q;
    logic [13:0] val_q, snap_q;
    wire rd_w = hsel_in && hready_in && htrans_in[1] && !hwrite_in;
    wire [13:0] a_w = haddr_in[13:0];
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence rd_at(a);
        rd_w ##0 a_w == a;
    endsequence
    // Checks assume reads stay clear of a result update in flight
    always_ff @(posedge clk_in) begin
        done_q <= conv_done_in;
        rd_q <= !rst_in && rd_w;
        if (conv_done_in && !done_q) val_q <= {conv_value_in, conv_overflow_in};
        if (rd_w && a_w == `ARR_ADDR_RESULT_HIGH) snap_q <= val_q;
    end
    chk_resp_okay: assert property (hresp_out == 1'b0) else $error("hresp not okay");
    chk_ready_high: assert property (hreadyout_out) else $error("wait state seen");
    chk_idle_zero: assert property (!rd_q |-> hrdata_out == 32'h0) else $error("hrdata not idle");
    chk_high_value: assert property (rd_at(`ARR_ADDR_RESULT_HIGH) |=>
        hrdata_out == {24'h0, snap_q[13:6]}) else $error("high byte wrong");
    chk_low_snap: assert property (rd_at(`ARR_ADDR_RESULT_LOW) |=>
        hrdata_out == {24'h0, snap_q[5:1], 2'h0, snap_q[0]}) else $error("low byte wrong");
    chk_raw_value: assert property (rd_at(`ARR_ADDR_RAW_RESULT) |=>
        hrdata_out == {18'h0, val_q}) else $error("raw result wrong");
    chk_status_upper: assert property (rd_at(`ARR_ADDR_IRQ_STATUS) |=>
        hrdata_out[31:2] == 30'h0) else $error("status upper bits set");
    chk_unmapped_zero: assert property (rd_w ##0 (a_w < 14'h3dc8 || a_w > 14'h3dd8) |=>
        hrdata_out == 32'h0) else $error("unmapped read not zero");
endmodule
bind arr_top arr_top_asserts chk_u (.clk_in(clk_in), .rst_in(rst_in),
    .conv_done_in(conv_done_in), .conv_value_in(conv_value_in),
    .conv_overflow_in(conv_overflow_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hready_in(hready_in),
    .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out));
`default_nettype wire

// File: sim/arr_top_bench.sv
// Self-checking bench for the result readout
`timescale 1ns/1ps
`default_nettype none
`include "arr_map.svh"
module arr_top_bench;
    logic clk_in = 0, rst_in = 1, done = 0, ovf = 0, hsel = 0, hwrite = 0, rd_ph = 0;
    logic [12:0] val = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [1:0] htrans = 0;
    logic hready, hresp, irq;
    int bad_count = 0, n_tests = 0;
    logic [31:0] exp_q[$];
    always #50 clk_in = ~clk_in;
    arr_top dut_u (.clk_in(clk_in), .rst_in(rst_in), .conv_done_in(done),
        .conv_value_in(val), .conv_overflow_in(ovf), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
        .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
        .hresp_out(hresp), .irq_out(irq));
    task chk(input logic [31:0] s, input logic [31:0] x);
        n_tests++;
        if (s !== x) begin
            bad_count++;
            $display("Error at %0t: got %h want %h", $time, s, x);
        end
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // For reads, d is the expected read data
    task xfer(input logic wr, input logic [13:0] a, input logic [31:0] d);
        hsel <= 1;
        htrans <= 2'h2;
        haddr <= {18'h0, a};
        hwrite <= wr;
        do @(posedge clk_in); while (hready !== 1'b1);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= d;
        rd_ph <= !wr;
        if (!wr) exp_q.push_back(d);
        do @(posedge clk_in); while (hready !== 1'b1);
        rd_ph <= 0;
    endtask
    always @(posedge clk_in) if (rd_ph && hready) chk(hrdata, exp_q.pop_front());
    // Register reads wait until the conversion has settled into the result
    task conv(input logic [12:0] v, input logic o);
        val <= v;
        ovf <= o;
        repeat (2) @(posedge clk_in);
        done <= 1;
        repeat (4) @(posedge clk_in);
        done <= 0;
        repeat (6) @(posedge clk_in);
    endtask
    task irq_is(input logic x);
        @(posedge clk_in);
        @(negedge clk_in);
        chk({31'h0, irq}, {31'h0, x});
        @(posedge clk_in);
    endtask
    function logic [31:0] lo(input logic [12:0] v, input logic o);
        return {24'h0, v[4:0], 2'h0, o};
    endfunction
    initial begin
        logic [12:0] v, w;
        void'($urandom(32'h91abbb18));
        repeat (10) @(posedge clk_in);
        rst_in <= 0;
        @(posedge clk_in);
        xfer(1, `ARR_ADDR_IRQ_MASK, 32'h3);
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 13'h1000 : 13'($urandom);
            conv(v, i[0]);
            irq_is(1);
            xfer(0, `ARR_ADDR_RESULT_HIGH, {24'h0, v[12:5]});
            xfer(0, `ARR_ADDR_RESULT_LOW, lo(v, i[0]));
            xfer(0, `ARR_ADDR_RAW_RESULT, {18'h0, v, i[0]});
            xfer(0, `ARR_ADDR_IRQ_STATUS, {30'h0, i[0], 1'b1});
            xfer(1, `ARR_ADDR_IRQ_STATUS, 32'h3);
            irq_is(0);
        end
        v = 13'($urandom);
        w = ~v;
        conv(v, 1);
        xfer(0, `ARR_ADDR_RESULT_HIGH, {24'h0, v[12:5]});
        conv(w, 0);
        xfer(0, `ARR_ADDR_RESULT_LOW, lo(v, 1));
        xfer(1, `ARR_ADDR_RESULT_LOW, 32'hff);
        xfer(0, `ARR_ADDR_RESULT_LOW, lo(v, 1));
        xfer(0, `ARR_ADDR_RESULT_HIGH, {24'h0, w[12:5]});
        xfer(0, `ARR_ADDR_RESULT_LOW, lo(w, 0));
        xfer(1, `ARR_ADDR_IRQ_MASK, 32'h0);
        irq_is(0);
        xfer(0, `ARR_ADDR_IRQ_STATUS, 32'h3);
        xfer(1, `ARR_ADDR_IRQ_MASK, 32'h2);
        irq_is(1);
        xfer(1, `ARR_ADDR_IRQ_STATUS, 32'h2);
        irq_is(0);
        xfer(0, 14'h3de0, 32'h0);
        wrap_up;
    end
    initial begin
        #400000;
        bad_count++;
        wrap_up;
    end
endmodule
`default_nettype wire
